// *** agl_gain_loop.sv ***
// Dual-channel automatic gain loop driving external variable gain amplifiers
module agl_gain_loop (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_master_reset_n,
  input wire logic i_sync_in_n,
  input wire agl_pkg::agl_chan_in_s i_chan_a,
  input wire agl_pkg::agl_chan_in_s i_chan_b,
  input wire logic i_table_we,
  input wire logic [agl_pkg::AGL_CODE_W-1:0] i_table_addr,
  input wire logic [agl_pkg::AGL_TABLE_W-1:0] i_table_data,
  input wire logic [1:0] i_detector_comb_order,
  input wire logic [1:0] i_loop_gain_shift,
  input wire logic [agl_pkg::AGL_INIT_W-1:0] i_integrator_init_a,
  input wire logic [agl_pkg::AGL_INIT_W-1:0] i_integrator_init_b,
  input wire logic i_hold_at_init,
  input wire logic i_inhibit_digital_gain,
  input wire logic [agl_pkg::AGL_DELAY_W-1:0] i_compensation_delay,
  output agl_pkg::agl_amp_s o_amp_a,
  output agl_pkg::agl_amp_s o_amp_b,
  output logic [agl_pkg::AGL_INIT_W-1:0] o_integrator_readback_a,
  output logic [agl_pkg::AGL_INIT_W-1:0] o_integrator_readback_b,
  output logic [agl_pkg::AGL_GAIN_W-1:0] o_digital_gain_shift_a,
  output logic [agl_pkg::AGL_GAIN_W-1:0] o_digital_gain_shift_b,
  output logic [agl_pkg::AGL_ALIGN_W-1:0] o_aligned_a,
  output logic [agl_pkg::AGL_ALIGN_W-1:0] o_aligned_b
);
  import agl_pkg::*;

  // ==========================================================================
  // Helpers
  // Saturate a widened integrator sum into the valid gain range
  function automatic logic [AGL_INTEG_W-1:0] saturate(input logic signed [AGL_INTEG_W+1:0] s);
    if (s < 0) begin
      saturate = AGL_INTEG_MIN;
    end else if (s > $signed({2'b00, AGL_INTEG_MAX})) begin
      saturate = AGL_INTEG_MAX;
    end else begin
      saturate = s[AGL_INTEG_W-1:0];
    end
  endfunction : saturate

  // ==========================================================================
  // Pin synchronisers for master reset and sync-in
  logic mr_meta_q;
  logic mr_sync_q;
  logic si_meta_q;
  logic si_sync_q;
  logic init_act;

  // Both pins are asynchronous to the sample clock, so two stages each
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mr_meta_q <= 1'b1;
      mr_sync_q <= 1'b1;
      si_meta_q <= 1'b1;
      si_sync_q <= 1'b1;
    end else begin
      mr_meta_q <= ~i_master_reset_n;
      mr_sync_q <= mr_meta_q;
      si_meta_q <= ~i_sync_in_n;
      si_sync_q <= si_meta_q;
    end
  end

  assign init_act = mr_sync_q || si_sync_q;

  // ==========================================================================
  // Shared lookup table
  logic [AGL_TABLE_W-1:0] table_q [AGL_TABLE_DEPTH];

  // Software loads the log, reference, deadband and error gain shape here;
  // the table is data, so it carries no reset and holds across master reset
  always_ff @(posedge i_clk_sys) begin
    if (i_table_we) begin
      table_q[i_table_addr] <= i_table_data;
    end
  end

  // ==========================================================================
  // Per-channel arrays so one generate body serves both channels
  agl_chan_in_s chan_in [AGL_NUM_CHAN];
  logic [AGL_INIT_W-1:0] init_val [AGL_NUM_CHAN];
  agl_amp_s amp [AGL_NUM_CHAN];
  logic [AGL_INIT_W-1:0] readback [AGL_NUM_CHAN];
  logic [AGL_GAIN_W-1:0] shift_out [AGL_NUM_CHAN];
  logic [AGL_ALIGN_W-1:0] aligned [AGL_NUM_CHAN];

  assign chan_in[0] = i_chan_a;
  assign chan_in[1] = i_chan_b;
  assign init_val[0] = i_integrator_init_a;
  assign init_val[1] = i_integrator_init_b;

  for (genvar c = 0; c < AGL_NUM_CHAN; c++) begin : g_chan
    logic [AGL_CODE_W-1:0] det_code;
    logic det_valid;
    agl_mode_e mode;
    logic signed [AGL_INTEG_W-1:0] err_shifted;
    logic signed [AGL_INTEG_W+1:0] integ_sum;
    logic [AGL_INTEG_W-1:0] integ_q;
    logic [AGL_GAIN_W-1:0] gain_d;
    logic [AGL_GAIN_W-1:0] gain_q;
    logic strobe_q;
    logic [AGL_GAIN_W-1:0] shift_code;
    logic [AGL_GAIN_W-1:0] dly_q [AGL_DELAY_DEPTH];
    logic [AGL_GAIN_W-1:0] shift_tap;
    logic [AGL_GAIN_W-1:0] shift_q;
    logic [AGL_MIX_W-1:0] mixer_q;
    logic [AGL_ALIGN_W-1:0] aligned_q;

    // ------------------------------------------------------------------------
    // Power detection, cleared while master reset or sync-in holds the loop
    agl_power_det u_det (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_clear(init_act),
      .i_sample(chan_in[c].sample),
      .i_comb_order(i_detector_comb_order),
      .o_code(det_code),
      .o_valid(det_valid)
    );

    // ------------------------------------------------------------------------
    // Loop mode: reset and sync force the init load, then hold or free run
    always_comb begin
      if (init_act) begin
        mode = AGL_MODE_INIT;
      end else if (i_hold_at_init) begin
        mode = AGL_MODE_HOLD;
      end else begin
        mode = AGL_MODE_RUN;
      end
    end

    // Table error scaled by 2^loop_gain; 8 bits shifted by up to 3 fits 11
    assign err_shifted = AGL_INTEG_W'($signed(table_q[det_code])) <<< i_loop_gain_shift;
    // Two guard bits keep the sum exact before clipping
    assign integ_sum = $signed({2'b00, integ_q}) + (AGL_INTEG_W+2)'(err_shifted);

    // ------------------------------------------------------------------------
    // Integrator: the feedback mux picks the channel's own init value or the
    // saturated sum; clipping at the ends stops overshoot into the range
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        integ_q <= AGL_INTEG_RST;
      end else begin
        unique case (mode)
          AGL_MODE_INIT, AGL_MODE_HOLD: begin
            integ_q <= {init_val[c], {AGL_RB_LSB{1'b0}}};
          end
          AGL_MODE_RUN: begin
            if (det_valid) begin
              integ_q <= saturate(integ_sum);
            end
          end
        endcase
      end
    end

    assign readback[c] = integ_q[AGL_INTEG_W-1:AGL_RB_LSB];

    // Fixed gain sends the inverted top of the init value to the amplifier
    always_comb begin
      unique case (mode)
        AGL_MODE_HOLD: begin
          gain_d = ~init_val[c][AGL_INIT_W-1:AGL_INIT_GAIN_LSB];
        end
        AGL_MODE_INIT, AGL_MODE_RUN: begin
          gain_d = integ_q[AGL_INTEG_W-1:AGL_GAIN_LSB];
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Amplifier interface: the strobe toggles only on a change, which keeps
    // needless edges off the analog path; each channel watches its own word
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        gain_q <= AGL_GAIN_RST;
        strobe_q <= 1'b1;
      end else begin
        gain_q <= gain_d;
        if (init_act) begin
          strobe_q <= 1'b1;
        end else if (gain_d != gain_q) begin
          strobe_q <= ~strobe_q;
        end
      end
    end

    assign amp[c].gain_word = gain_q;
    assign amp[c].strobe = strobe_q;

    // ------------------------------------------------------------------------
    // Digital gain compensation: inverse of the analog word
    assign shift_code = ~gain_q;

    // Delay line so the digital step lands with the analog step; software
    // picks the tap (7 without strobes, 8 with them)
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        for (int i = 0; i < AGL_DELAY_DEPTH; i++) begin
          dly_q[i] <= AGL_SHIFT_UNITY;
        end
      end else begin
        dly_q[0] <= shift_code;
        for (int i = 1; i < AGL_DELAY_DEPTH; i++) begin
          dly_q[i] <= dly_q[i-1];
        end
      end
    end

    // Tap 0 means no delay at all
    assign shift_tap = (i_compensation_delay == '0) ? shift_code :
                       dly_q[i_compensation_delay - 1'b1];

    // Inhibit leaves the sample at full-scale position, no compensation
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        shift_q <= AGL_SHIFT_UNITY;
      end else begin
        shift_q <= i_inhibit_digital_gain ? AGL_SHIFT_UNITY : shift_tap;
      end
    end

    // Mixer sample waits one cycle so it meets the registered shift code
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        mixer_q <= '0;
      end else begin
        mixer_q <= chan_in[c].mixer;
      end
    end

    // ------------------------------------------------------------------------
    // Alignment: sign-extend to 22 bits, then shift up by the code; code 7
    // puts the sample MSB at bit 21, lower codes sit one place lower each
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        aligned_q <= '0;
      end else begin
        aligned_q <= AGL_ALIGN_W'($signed(mixer_q)) << shift_q;
      end
    end

    assign shift_out[c] = shift_q;
    assign aligned[c] = aligned_q;
  end

  // ==========================================================================
  // Output mapping
  assign o_amp_a = amp[0];
  assign o_amp_b = amp[1];
  assign o_integrator_readback_a = readback[0];
  assign o_integrator_readback_b = readback[1];
  assign o_digital_gain_shift_a = shift_out[0];
  assign o_digital_gain_shift_b = shift_out[1];
  assign o_aligned_a = aligned[0];
  assign o_aligned_b = aligned[1];

endmodule : agl_gain_loop

// *** agl_gain_loop_bench.sv ***
// Self-checking bench for the dual-channel gain loop
module agl_gain_loop_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import agl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0, i_master_reset_n = 1'b1, i_sync_in_n = 1'b1;
  agl_chan_in_s i_chan_a = '0, i_chan_b = '0;
  logic i_table_we = 1'b0, i_hold_at_init = 1'b1, i_inhibit_digital_gain = 1'b0;
  logic [4:0] i_table_addr = '0, i_compensation_delay = '0;
  logic [7:0] i_table_data = '0, i_integrator_init_a = '0, i_integrator_init_b = '0;
  logic [1:0] i_detector_comb_order = '0, i_loop_gain_shift = '0;
  agl_amp_s o_amp_a, o_amp_b;
  logic [7:0] o_integrator_readback_a, o_integrator_readback_b;
  logic [2:0] o_digital_gain_shift_a, o_digital_gain_shift_b, vg_a, vg_b;
  logic [21:0] o_aligned_a, o_aligned_b;
  int nl_a, nl_b, bad_count = 0, checks_done = 0;

  // ==========================================================================
  // Clock, design and amplifier models
  always #50 i_clk_sys = ~i_clk_sys;
  agl_gain_loop dut (.i_clk_sys, .i_rst_b, .i_master_reset_n, .i_sync_in_n, .i_chan_a, .i_chan_b, .i_table_we,
    .i_table_addr, .i_table_data, .i_detector_comb_order, .i_loop_gain_shift, .i_integrator_init_a,
    .i_integrator_init_b, .i_hold_at_init, .i_inhibit_digital_gain, .i_compensation_delay, .o_amp_a, .o_amp_b,
    .o_integrator_readback_a, .o_integrator_readback_b, .o_digital_gain_shift_a, .o_digital_gain_shift_b,
    .o_aligned_a, .o_aligned_b);
  agl_vga_model u_vga_a (.i_clk_sys, .i_amp(o_amp_a), .o_gain(vg_a), .o_latches(nl_a));
  agl_vga_model u_vga_b (.i_clk_sys, .i_amp(o_amp_b), .o_gain(vg_b), .o_latches(nl_b));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", name, expv, seen);
    end
  endtask : check
  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step
  // Whole table written back to back, strobe held high throughout
  task automatic fill(input logic [7:0] base, input logic [4:0] at, input logic [7:0] val);
    i_table_we = 1'b1;
    for (int a = 0; a < AGL_TABLE_DEPTH; a++) begin
      i_table_addr = 5'(a);
      i_table_data = (5'(a) == at) ? val : base;
      step(1);
    end
    i_table_we = 1'b0;
  endtask : fill
  // Cycles between two readback changes; the first change only syncs
  task automatic period(output int n);
    logic [7:0] v;
    repeat (2) begin
      n = 0;
      v = o_integrator_readback_a;
      while (o_integrator_readback_a === v && n < 200) begin
        step(1);
        n++;
      end
    end
  endtask : period
  function automatic logic [21:0] al(input logic [14:0] m, input logic [2:0] s);
    return 22'(signed'(m)) << s;
  endfunction : al
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check("gain_a", o_amp_a.gain_word, AGL_GAIN_RST);
    check("strobes", {o_amp_a.strobe, o_amp_b.strobe}, 2'h3);
    check("rb_a", o_integrator_readback_a, 8'h00);
    check("shift_a", o_digital_gain_shift_a, AGL_SHIFT_UNITY);
    check("aligned_a", o_aligned_a, 22'h000000);
  endtask : t_reset
  task automatic t_hold;
    int n, d;
    i_integrator_init_a = 8'hA4;
    i_integrator_init_b = 8'h5C;
    i_chan_a.mixer = 15'h4001;
    i_chan_b.mixer = 15'h0003;
    step(8);
    check("hold_gain_a", o_amp_a.gain_word, 3'h2);
    check("hold_gain_b", o_amp_b.gain_word, 3'h5);
    check("hold_rb_a", o_integrator_readback_a, 8'hA4);
    check("hold_rb_b", o_integrator_readback_b, 8'h5C);
    check("vga_a", vg_a, 3'h2);
    check("shift_a", o_digital_gain_shift_a, 3'h5);
    check("aligned_a", o_aligned_a, al(15'h4001, 3'h5));
    check("shift_b", o_digital_gain_shift_b, 3'h2);
    check("aligned_b", o_aligned_b, al(15'h0003, 3'h2));
    i_inhibit_digital_gain = 1'b1;
    step(4);
    check("inh_shift_a", o_digital_gain_shift_a, 3'h7);
    check("inh_aligned_a", o_aligned_a, al(15'h4001, 3'h7));
    check("inh_shift_b", o_digital_gain_shift_b, 3'h7);
    i_inhibit_digital_gain = 1'b0;
    i_compensation_delay = 5'h08; // Strobes in use, so eight clocks
    step(12);
    i_integrator_init_a = 8'h20;
    for (n = 0; o_amp_a.gain_word !== 3'h6 && n < 20; n++) step(1);
    for (d = 0; o_digital_gain_shift_a !== 3'h1 && d < 40; d++) step(1);
    check("shift_lag", d, 9);
    i_compensation_delay = 5'h00;
    step(12);
  endtask : t_hold
  task automatic t_sat;
    fill(8'h7F, 5'h00, 8'h7F);
    i_loop_gain_shift = 2'h3;
    i_hold_at_init = 1'b0;
    step(60);
    check("sat_rb_hi", o_integrator_readback_a, 8'hFF);
    check("sat_gain_hi", o_amp_a.gain_word, 3'h7);
    check("sat_vga_hi", vg_a, 3'h7);
    fill(8'h80, 5'h00, 8'h80);
    step(60);
    check("sat_rb_lo", o_integrator_readback_a, 8'h00);
    check("sat_vga_lo", vg_a, 3'h0);
  endtask : t_sat
  task automatic t_rate;
    int n;
    fill(8'h01, 5'h00, 8'h01);
    for (int l = 0; l < 4; l++) begin
      i_loop_gain_shift = 2'(l);
      period(n);
      check("rate_period", n, 64 >> l);
    end
  endtask : t_rate
  task automatic t_det;
    logic [9:0] smp [8] = '{10'h000, 10'h002, 10'h003, 10'h005, 10'h009, 10'h064, 10'h2D4, 10'h1FF};
    logic [4:0] code [8] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h08, 5'h16, 5'h1C, 5'h1F};
    int n;
    i_loop_gain_shift = 2'h0;
    i_chan_b.sample = 10'h001;
    for (int o = 0; o < 4; o++) begin
      for (int k = 0; k < 8; k++) begin
        i_hold_at_init = 1'b1;
        i_detector_comb_order = 2'(o);
        i_chan_a.sample = smp[k];
        fill(8'h00, code[k], 8'h08);
        i_hold_at_init = 1'b0;
        step(60);
        period(n);
        check("det_period", n, 8);
      end
    end
  endtask : t_det
  task automatic t_indep;
    int na, nb;
    i_hold_at_init = 1'b1;
    i_loop_gain_shift = 2'h3;
    i_chan_a.sample = 10'h1FF;
    fill(8'h00, 5'h1F, 8'h7F);
    i_hold_at_init = 1'b0;
    step(6);
    na = nl_a;
    nb = nl_b;
    step(60);
    check("indep_gain_a", o_amp_a.gain_word, 3'h7);
    check("indep_moved_a", nl_a > na, 1'b1);
    check("indep_still_b", nl_b, nb);
  endtask : t_indep
  task automatic t_init;
    i_integrator_init_a = 8'h64;
    for (int p = 0; p < 2; p++) begin
      i_master_reset_n = (p != 0);
      i_sync_in_n = (p == 0);
      step(8);
      check("init_strobes", {o_amp_a.strobe, o_amp_b.strobe}, 2'h3);
      check("init_rb_a", o_integrator_readback_a, 8'h64);
      i_master_reset_n = 1'b1;
      i_sync_in_n = 1'b1;
      step(8);
    end
  endtask : t_init

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    step(3);
    t_reset;
    i_rst_b = 1'b1;
    t_hold;
    t_sat;
    t_rate;
    t_det;
    t_indep;
    t_init;
    close_out;
  end
  // The whole run needs well under half this span
  initial begin
    step(20000);
    bad_count++;
    close_out;
  end
endmodule : agl_gain_loop_bench

// *** agl_gain_loop_chk.sv ***
// Port-level assertions for the dual-channel gain loop
module agl_gain_loop_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_master_reset_n,
  input wire logic i_sync_in_n,
  input wire agl_pkg::agl_chan_in_s i_chan_a,
  input wire logic i_hold_at_init,
  input wire logic i_inhibit_digital_gain,
  input wire logic [agl_pkg::AGL_DELAY_W-1:0] i_compensation_delay,
  input wire logic [agl_pkg::AGL_INIT_W-1:0] i_integrator_init_a,
  input wire logic [agl_pkg::AGL_INIT_W-1:0] i_integrator_init_b,
  input wire agl_pkg::agl_amp_s o_amp_a,
  input wire agl_pkg::agl_amp_s o_amp_b,
  input wire logic [agl_pkg::AGL_INIT_W-1:0] o_integrator_readback_a,
  input wire logic [agl_pkg::AGL_GAIN_W-1:0] o_digital_gain_shift_a,
  input wire logic [agl_pkg::AGL_ALIGN_W-1:0] o_aligned_a
);
  import agl_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] run_q, hold_q, low_q, cfg_q;

  // ==========================================================================
  // Settling counters
  // Margins cover the two-stage pin synchronisers plus the output registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_q <= 3'h0;
      hold_q <= 3'h0;
      low_q <= 3'h0;
      cfg_q <= 3'h0;
    end else begin
      run_q <= !(i_master_reset_n && i_sync_in_n) ? 3'h0 : run_q + 3'(run_q != 3'h7);
      hold_q <= (!i_hold_at_init || run_q < 3'h4 || $changed(i_integrator_init_a) ||
                 $changed(i_integrator_init_b)) ? 3'h0 : hold_q + 3'(hold_q != 3'h7);
      low_q <= (i_hold_at_init || run_q < 3'h4) ? 3'h0 : low_q + 3'(low_q != 3'h7);
      cfg_q <= (i_inhibit_digital_gain || i_compensation_delay != 5'h00) ? 3'h0 : cfg_q + 3'(cfg_q != 3'h7);
    end
  end

  // ==========================================================================
  // Sequences and assertions
  sequence s_init_held;
    (!i_master_reset_n || !i_sync_in_n) [*6];
  endsequence
  sequence s_rb_steady;
    low_q >= 3'h3 && o_integrator_readback_a == $past(o_integrator_readback_a) &&
      o_integrator_readback_a == $past(o_integrator_readback_a, 2);
  endsequence

  a_strobe_follow_a: assert property (run_q >= 3'h5 |->
      $changed(o_amp_a.strobe) == $changed(o_amp_a.gain_word))
    else $error("strobe A out of step with its gain word");
  a_strobe_follow_b: assert property (run_q >= 3'h5 |->
      $changed(o_amp_b.strobe) == $changed(o_amp_b.gain_word))
    else $error("strobe B out of step with its gain word");
  a_init_strobe_high: assert property (s_init_held |-> o_amp_a.strobe && o_amp_b.strobe)
    else $error("strobes low during init");
  a_init_load_ic: assert property (s_init_held |-> o_integrator_readback_a == $past(i_integrator_init_a))
    else $error("integrator not loaded from init value");
  a_rb_gain_top: assert property (s_rb_steady |-> o_amp_a.gain_word == o_integrator_readback_a[7:5])
    else $error("gain word differs from integrator top bits");
  a_hold_gain_inv: assert property (hold_q >= 3'h3 |->
      o_amp_a.gain_word == ~$past(i_integrator_init_a[7:5]) &&
      o_amp_b.gain_word == ~$past(i_integrator_init_b[7:5]))
    else $error("fixed gain word wrong");
  a_hold_rb_init: assert property (hold_q >= 3'h3 |-> o_integrator_readback_a == $past(i_integrator_init_a))
    else $error("held integrator left its init value");
  a_shift_inverse: assert property (cfg_q >= 3'h2 |-> o_digital_gain_shift_a == ~$past(o_amp_a.gain_word))
    else $error("shift code not inverse of gain word");
  a_inhibit_unity: assert property ((i_inhibit_digital_gain && i_compensation_delay == 5'h00) [*3]
      |-> o_digital_gain_shift_a == AGL_SHIFT_UNITY)
    else $error("inhibited shift not unity");
  a_align_shift: assert property (run_q >= 3'h4 |->
      o_aligned_a == (AGL_ALIGN_W'(signed'($past(i_chan_a.mixer, 2))) << $past(o_digital_gain_shift_a)))
    else $error("aligned sample wrong");
endmodule : agl_gain_loop_chk

bind agl_gain_loop agl_gain_loop_chk u_chk (.i_clk_sys, .i_rst_b, .i_master_reset_n, .i_sync_in_n, .i_chan_a,
  .i_hold_at_init, .i_inhibit_digital_gain, .i_compensation_delay, .i_integrator_init_a, .i_integrator_init_b,
  .o_amp_a, .o_amp_b, .o_integrator_readback_a, .o_digital_gain_shift_a, .o_aligned_a);

// *** agl_pkg.sv ***
// Constants and carrier types shared by the gain loop and its power detector
package agl_pkg;

  // ==========================================================================
  // Widths
  localparam int AGL_SAMPLE_W = 10;          // Detector input sample, two's complement
  localparam int AGL_DET_W = 9;              // Unsigned detector output
  localparam int AGL_CODE_W = 5;             // Exponent over mantissa
  localparam int AGL_EXP_W = 3;
  localparam int AGL_MANT_W = 2;
  localparam int AGL_TABLE_DEPTH = 32;
  localparam int AGL_TABLE_W = 8;
  localparam int AGL_INTEG_W = 11;
  localparam int AGL_GAIN_W = 3;
  localparam int AGL_INIT_W = 8;
  localparam int AGL_MIX_W = 15;
  localparam int AGL_ALIGN_W = 22;
  localparam int AGL_DELAY_W = 5;
  localparam int AGL_DELAY_DEPTH = 32;
  localparam int AGL_NUM_CHAN = 2;

  // ==========================================================================
  // Detector comb filter
  localparam int AGL_DECIM = 8;
  localparam int AGL_DECIM_LOG2 = 3;
  localparam int AGL_COMB_BASE_ORDER = 2;
  localparam int AGL_COMB_MAX_ORDER = 4;
  localparam int AGL_CIC_W = AGL_DET_W + AGL_DECIM_LOG2 * AGL_COMB_MAX_ORDER;

  // ==========================================================================
  // Field positions and limits
  localparam int AGL_RB_LSB = 3;             // Readback is integrator bits 10:3
  localparam int AGL_GAIN_LSB = 8;           // Gain word is integrator bits 10:8
  localparam int AGL_INIT_GAIN_LSB = 5;      // Gain part of the init value, bits 7:5
  localparam logic [AGL_INTEG_W-1:0] AGL_INTEG_MAX = 11'h7FF;
  localparam logic [AGL_INTEG_W-1:0] AGL_INTEG_MIN = 11'h000;
  localparam logic [AGL_DET_W-1:0] AGL_DET_MAX = 9'h1FF;

  // ==========================================================================
  // Reset values
  localparam logic [AGL_GAIN_W-1:0] AGL_GAIN_RST = 3'h0;
  localparam logic [AGL_GAIN_W-1:0] AGL_SHIFT_UNITY = 3'h7;   // Sample MSB at bit 21
  localparam logic [AGL_INTEG_W-1:0] AGL_INTEG_RST = 11'h000;

  // ==========================================================================
  // Loop mode and carriers
  typedef enum logic [1:0] {
    AGL_MODE_INIT,
    AGL_MODE_HOLD,
    AGL_MODE_RUN
  } agl_mode_e;

  typedef struct packed {
    logic [AGL_GAIN_W-1:0] gain_word;
    logic strobe;
  } agl_amp_s;

  typedef struct packed {
    logic [AGL_SAMPLE_W-1:0] sample;
    logic [AGL_MIX_W-1:0] mixer;
  } agl_chan_in_s;

endpackage : agl_pkg

// *** agl_power_det.sv ***
// Power detector: absolute value, decimating comb filter and fixed-to-float code
module agl_power_det (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic [agl_pkg::AGL_SAMPLE_W-1:0] i_sample,
  input wire logic [1:0] i_comb_order,
  output logic [agl_pkg::AGL_CODE_W-1:0] o_code,
  output logic o_valid
);
  import agl_pkg::*;

  // ==========================================================================
  // Helpers
  // Setting 0 (and unused 3) keeps the base order; 1 and 2 narrow the band
  function automatic int order_of(input logic [1:0] sel);
    order_of = (sel == 2'h1) ? AGL_COMB_BASE_ORDER + 1 :
               (sel == 2'h2) ? AGL_COMB_BASE_ORDER + 2 : AGL_COMB_BASE_ORDER;
  endfunction : order_of

  // Leading-one position less one becomes exponent, the next two bits the mantissa
  function automatic logic [AGL_CODE_W-1:0] to_float(input logic [AGL_DET_W-1:0] x);
    logic [AGL_EXP_W-1:0] e;
    logic [AGL_MANT_W-1:0] m;
    e = '0;
    m = x[1:0];
    for (int i = 2; i < AGL_DET_W; i++) begin
      if (x[i]) begin
        e = AGL_EXP_W'(i - 1);
        m = AGL_MANT_W'(x >> (i - 2));
      end
    end
    to_float = {e, m};
  endfunction : to_float

  logic [AGL_SAMPLE_W-1:0] mag_full;
  logic [AGL_DET_W-1:0] mag;
  logic [AGL_DECIM_LOG2-1:0] phase_q;
  logic dump;
  logic [AGL_CIC_W-1:0] integ_q [AGL_COMB_MAX_ORDER];
  logic [AGL_CIC_W-1:0] comb_in [AGL_COMB_MAX_ORDER+1];
  logic [AGL_CIC_W-1:0] comb_dly_q [AGL_COMB_MAX_ORDER];
  logic [AGL_CIC_W-1:0] scaled;
  int order;

  // ==========================================================================
  // Absolute value; the single -full-scale code clips to the top magnitude
  assign mag_full = i_sample[AGL_SAMPLE_W-1] ? AGL_SAMPLE_W'(-i_sample) : i_sample;
  assign mag = mag_full[AGL_SAMPLE_W-1] ? AGL_DET_MAX : mag_full[AGL_DET_W-1:0];
  assign order = order_of(i_comb_order);
  assign dump = (phase_q == AGL_DECIM_LOG2'(AGL_DECIM - 1));

  // Decimation phase, one output every eight clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_q <= '0;
    end else if (i_clear) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end

  // Integrators wrap modulo 2^width, which the comb differences undo
  for (genvar k = 0; k < AGL_COMB_MAX_ORDER; k++) begin : g_integ
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        integ_q[k] <= '0;
      end else if (i_clear) begin
        integ_q[k] <= '0;
      end else if (k == 0) begin
        integ_q[k] <= integ_q[k] + AGL_CIC_W'(mag);
      end else begin
        integ_q[k] <= integ_q[k] + integ_q[(k > 0) ? k - 1 : 0];
      end
    end
  end

  // Combs at the low rate; stages beyond the selected order pass through
  assign comb_in[0] = integ_q[order-1];
  for (genvar k = 0; k < AGL_COMB_MAX_ORDER; k++) begin : g_comb
    assign comb_in[k+1] = (k < order) ? comb_in[k] - comb_dly_q[k] : comb_in[k];
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        comb_dly_q[k] <= '0;
      end else if (i_clear) begin
        comb_dly_q[k] <= '0;
      end else if (dump) begin
        comb_dly_q[k] <= comb_in[k];
      end
    end
  end

  // Remove the filter's dc gain of 8^order so full scale stays nine bits
  assign scaled = comb_in[AGL_COMB_MAX_ORDER] >> (AGL_DECIM_LOG2 * order);

  // Registered code with its one-cycle valid pulse
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_code <= '0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= dump && !i_clear;
      if (dump) begin
        o_code <= to_float(scaled[AGL_DET_W-1:0]);
      end
    end
  end

endmodule : agl_power_det

// *** agl_vga_model.sv ***
// Behavioural model of an external variable gain amplifier
module agl_vga_model (
  input wire logic i_clk_sys,
  input wire agl_pkg::agl_amp_s i_amp,
  output logic [agl_pkg::AGL_GAIN_W-1:0] o_gain,
  output int o_latches
);
  import agl_pkg::*;
  logic strobe_q = 1'b1;

  // Latch on either strobe edge; a quiet strobe leaves the analog gain alone
  initial begin
    o_gain = 3'h0;
    o_latches = 0;
  end
  always @(posedge i_clk_sys) begin
    if (i_amp.strobe !== strobe_q) begin
      o_gain <= i_amp.gain_word; // Three-bit word, 6 dB per step
      o_latches <= o_latches + 1; // Counted so the bench can spot stray toggles
    end
    strobe_q <= i_amp.strobe;
  end
endmodule : agl_vga_model
